// >>> verilog/dmc_defines.svh
// Register map, field positions, reset values and codes of the DMA control block
`ifndef DMC_DEFINES_SVH
`define DMC_DEFINES_SVH
// ----------------------------------------
// Register bus
// ----------------------------------------
`define DMC_ADDR_W 8
`define DMC_DATA_W 16
`define DMC_OFF_OPER 8'h00
`define DMC_OFF_SEL01 8'h04
`define DMC_OFF_SEL23 8'h08
`define DMC_OFF_STATUS 8'h0C
// ----------------------------------------
// Operation register fields and register reset values
// ----------------------------------------
`define DMC_BIT_GLOBAL_EN 0
`define DMC_BIT_NMI_FLAG 1
`define DMC_BIT_ADDR_ERR_FLAG 2
`define DMC_OPER_RESET 3'h0
`define DMC_SEL_RESET 16'h0000
// ----------------------------------------
// Selector field layout
// ----------------------------------------
`define DMC_HI_MID_MSB 15
`define DMC_HI_MID_LSB 10
`define DMC_HI_RES_MSB 9
`define DMC_HI_RES_LSB 8
`define DMC_LO_MID_MSB 7
`define DMC_LO_MID_LSB 2
`define DMC_LO_RES_MSB 1
`define DMC_LO_RES_LSB 0
// ----------------------------------------
// Request source codes
// ----------------------------------------
`define DMC_RS_PERIPH 4'h8
`define DMC_MID_SP0 6'h08
`define DMC_MID_SP2 6'h0A
`define DMC_MID_USB 6'h1C
`define DMC_RES_SP_TX 2'h1
`define DMC_RES_SP_RX 2'h2
`define DMC_RES_USB_TX 2'h3
`define DMC_RES_USB_RX 2'h0
// ----------------------------------------
// Request queue
// ----------------------------------------
`define DMC_FIFO_DEPTH 8
`define DMC_FIFO_WIDTH 2
`endif

// >>> verilog/dmc_pkg.sv
// Types shared by the DMA control block modules
package dmc_pkg;
	typedef logic [1:0] dmc_chan_id_type;
	typedef enum logic [2:0] {
		SRC_NONE,
		SRC_SP0_TX,
		SRC_SP0_RX,
		SRC_SP2_TX,
		SRC_SP2_RX,
		SRC_USB_TX,
		SRC_USB_RX
	} dmc_src_type;
endpackage : dmc_pkg

// >>> verilog/dmc_fifo_if.sv
// Valid/ready carrier between the control logic and the request queue
interface dmc_fifo_if #(
	parameter int WIDTH = 2
);
	logic             in_valid;
	logic             in_ready;
	logic [WIDTH-1:0] in_data;
	logic             out_valid;
	logic             out_ready;
	logic [WIDTH-1:0] out_data;
	modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
	modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : dmc_fifo_if

// >>> verilog/dmc_route.sv
// Per-channel peripheral request routing from the selector fields
`include "dmc_defines.svh"
module dmc_route (
	input  wire logic [15:0] sel01,
	input  wire logic [15:0] sel23,
	input  wire logic [15:0] rs_code,
	input  wire logic [5:0]  periph_req,
	output logic      [3:0]  chan_req
);
	// ----------------------------------------
	// Source decode
	// ----------------------------------------
	function automatic dmc_pkg::dmc_src_type decode_src(input logic [5:0] mid, input logic [1:0] res,
		input logic [3:0] rs);
		dmc_pkg::dmc_src_type src;
		src = dmc_pkg::SRC_NONE;
		if (rs == `DMC_RS_PERIPH) begin
			if (mid == `DMC_MID_SP0 && res == `DMC_RES_SP_TX) src = dmc_pkg::SRC_SP0_TX;
			if (mid == `DMC_MID_SP0 && res == `DMC_RES_SP_RX) src = dmc_pkg::SRC_SP0_RX;
			if (mid == `DMC_MID_SP2 && res == `DMC_RES_SP_TX) src = dmc_pkg::SRC_SP2_TX;
			if (mid == `DMC_MID_SP2 && res == `DMC_RES_SP_RX) src = dmc_pkg::SRC_SP2_RX;
			if (mid == `DMC_MID_USB && res == `DMC_RES_USB_TX) src = dmc_pkg::SRC_USB_TX;
			if (mid == `DMC_MID_USB && res == `DMC_RES_USB_RX) src = dmc_pkg::SRC_USB_RX;
		end
		return src;
	endfunction : decode_src

	// ----------------------------------------
	// Channel loop
	// ----------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < 4; ch++) begin : g_ch
			logic [15:0]          sel;
			dmc_pkg::dmc_src_type src;
			logic                 hit;
			assign sel = (ch < 2) ? sel01 : sel23;
			assign chan_req[ch] = hit;
			always_comb begin
				if (ch % 2 == 1) begin
					src = decode_src(sel[`DMC_HI_MID_MSB:`DMC_HI_MID_LSB], sel[`DMC_HI_RES_MSB:`DMC_HI_RES_LSB],
						rs_code[ch*4 +: 4]);
				end else begin
					src = decode_src(sel[`DMC_LO_MID_MSB:`DMC_LO_MID_LSB], sel[`DMC_LO_RES_MSB:`DMC_LO_RES_LSB],
						rs_code[ch*4 +: 4]);
				end
				unique case (src)
					dmc_pkg::SRC_SP0_TX: hit = periph_req[0];
					dmc_pkg::SRC_SP0_RX: hit = periph_req[1];
					dmc_pkg::SRC_SP2_TX: hit = periph_req[2];
					dmc_pkg::SRC_SP2_RX: hit = periph_req[3];
					dmc_pkg::SRC_USB_TX: hit = periph_req[4];
					dmc_pkg::SRC_USB_RX: hit = periph_req[5];
					default:             hit = 1'b0;
				endcase
			end
		end
	endgenerate
endmodule : dmc_route

// >>> verilog/dmc_fifo.sv
// Shift-register request queue with valid/ready on both sides
module dmc_fifo #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 8
) (
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic ce,
	input  wire logic flush,
	dmc_fifo_if.fifo  q
);
	localparam int CW = $clog2(DEPTH + 1);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] word;
		logic [CW-1:0]               count;
		logic                        nonempty;
		logic                        full;
	} dmc_fifo_state_type;

	dmc_fifo_state_type s_reg;
	dmc_fifo_state_type s_next;
	logic               push;
	logic               pop;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_next = s_reg;
		push = q.in_valid & ~s_reg.full;
		pop = q.out_ready & s_reg.nonempty;
		if (pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				s_next.word[i] = s_reg.word[i+1];
			end
			s_next.count = s_reg.count - CW'(1);
		end
		if (push) begin
			s_next.word[pop ? s_reg.count - CW'(1) : s_reg.count] = q.in_data;
			s_next.count = s_next.count + CW'(1);
		end
		if (flush) begin
			s_next.count = '0;
		end
		s_next.nonempty = (s_next.count != '0);
		s_next.full = (s_next.count == CW'(DEPTH));
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_reg <= '0;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	assign q.in_ready = ~s_reg.full;
	assign q.out_valid = s_reg.nonempty;
	assign q.out_data = s_reg.word[0];
endmodule : dmc_fifo

// >>> verilog/dmc_top.sv
// DMA global control, abort flags, request source selection and request queue
//
// Summary of operation
// - NMI sets the abort flag, even with no channel active.
// - On NMI a channel finishes its current transfer unit, then halts.
// - Abort flag clears only by writing 0 after reading 1, or reset.
// - While the abort flag is 1, no channel may start transfers.
// - Channel runs only with master and channel enable 1 and all flags 0.
// - Clearing the master enable terminates transfers on every channel.
// - Master enable is bit 0, resets to 0, gates all channels.
// - Two 16-bit read/write selectors: channels 0/1 and channels 2/3.
// - Selector source used only when the channel resource code is 1000.
// - High channel ID in bits 15:8, low channel ID in bits 7:0.
// - Module and resource IDs pick serial port 0, 2 or USB direction.
// - Address error sets a flag disabling all transfers; read-1-write-0 clears.
//
// Chosen here: the plain strobed port and the placing of the registers.
`include "dmc_defines.svh"
module dmc_top (
	input  wire logic        CORE_CLK,
	input  wire logic        ARST_N,
	input  wire logic        CE,
	input  wire logic        MANUAL_RST,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [15:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [15:0] REG_RDATA,
	input  wire logic        NMI_EVENT,
	input  wire logic        ADDR_ERROR_EVENT,
	input  wire logic [3:0]  CHANNEL_ENABLE,
	input  wire logic [3:0]  TRANSFER_END_FLAG,
	input  wire logic [15:0] RESOURCE_SELECT_CODE,
	input  wire logic [3:0]  UNIT_BUSY,
	input  wire logic [5:0]  PERIPH_REQ,
	output logic      [3:0]  CH_RUN,
	output logic             REQ_VALID,
	output logic      [1:0]  REQ_CHANNEL,
	input  wire logic        REQ_READY
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic        global_transfer_enable;
		logic        nmi_abort_flag;
		logic        addr_error_flag;
		logic        nmi_armed;
		logic        addr_err_armed;
		logic [15:0] request_source_select_ch01;
		logic [15:0] request_source_select_ch23;
		logic [3:0]  run;
		logic [3:0]  pend;
		logic [15:0] rdata;
	} dmc_top_state_type;

	localparam dmc_top_state_type RESET_STATE = '{
		global_transfer_enable: 1'(`DMC_OPER_RESET),
		nmi_abort_flag:         1'b0,
		addr_error_flag:        1'b0,
		nmi_armed:              1'b0,
		addr_err_armed:         1'b0,
		request_source_select_ch01: `DMC_SEL_RESET,
		request_source_select_ch23: `DMC_SEL_RESET,
		run:                    4'h0,
		pend:                   4'h0,
		rdata:                  16'h0000
	};

	dmc_top_state_type s_reg;
	dmc_top_state_type s_next;
	logic [3:0]        permit;
	logic [3:0]        chan_req;
	logic              wr_oper;
	logic              rd_oper;
	logic              pushed;
	dmc_pkg::dmc_chan_id_type push_ch;

	dmc_fifo_if #(.WIDTH(`DMC_FIFO_WIDTH)) q_if ();

	// ----------------------------------------
	// Request routing and queue
	// ----------------------------------------
	dmc_route u_route (
		.sel01      (s_reg.request_source_select_ch01),
		.sel23      (s_reg.request_source_select_ch23),
		.rs_code    (RESOURCE_SELECT_CODE),
		.periph_req (PERIPH_REQ),
		.chan_req   (chan_req)
	);

	dmc_fifo #(.WIDTH(`DMC_FIFO_WIDTH), .DEPTH(`DMC_FIFO_DEPTH)) u_fifo (
		.clk    (CORE_CLK),
		.arst_n (ARST_N),
		.ce     (CE),
		.flush  (MANUAL_RST),
		.q      (q_if.fifo)
	);

	// ----------------------------------------
	// Channel permission
	// ----------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < 4; ch++) begin : g_permit
			assign permit[ch] = s_reg.global_transfer_enable & CHANNEL_ENABLE[ch]
				& ~TRANSFER_END_FLAG[ch] & ~s_reg.nmi_abort_flag & ~s_reg.addr_error_flag;
		end
	endgenerate

	// ----------------------------------------
	// Queue push arbitration
	// ----------------------------------------
	always_comb begin
		push_ch = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (s_reg.pend[i]) push_ch = 2'(i);
		end
	end

	assign q_if.in_valid = |s_reg.pend;
	assign q_if.in_data = push_ch;
	assign q_if.out_ready = REQ_READY;
	assign pushed = q_if.in_valid & q_if.in_ready;

	assign wr_oper = REG_WR && REG_ADDR == `DMC_OFF_OPER;
	assign rd_oper = REG_RD && REG_ADDR == `DMC_OFF_OPER;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_next = s_reg;
		// Register writes
		if (wr_oper) begin
			s_next.global_transfer_enable = REG_WDATA[`DMC_BIT_GLOBAL_EN];
			if (!REG_WDATA[`DMC_BIT_NMI_FLAG] && s_reg.nmi_armed) s_next.nmi_abort_flag = 1'b0;
			if (!REG_WDATA[`DMC_BIT_ADDR_ERR_FLAG] && s_reg.addr_err_armed) s_next.addr_error_flag = 1'b0;
			s_next.nmi_armed = 1'b0;
			s_next.addr_err_armed = 1'b0;
		end
		if (REG_WR && REG_ADDR == `DMC_OFF_SEL01) s_next.request_source_select_ch01 = REG_WDATA;
		if (REG_WR && REG_ADDR == `DMC_OFF_SEL23) s_next.request_source_select_ch23 = REG_WDATA;
		// Reading a set flag arms its clear
		if (rd_oper) begin
			if (s_reg.nmi_abort_flag) s_next.nmi_armed = 1'b1;
			if (s_reg.addr_error_flag) s_next.addr_err_armed = 1'b1;
		end
		// Events set flags after any clear, so a set wins
		if (NMI_EVENT) s_next.nmi_abort_flag = 1'b1;
		if (ADDR_ERROR_EVENT) s_next.addr_error_flag = 1'b1;
		// Running channels finish their current unit
		s_next.run = permit | (s_reg.run & UNIT_BUSY);
		// Pending peripheral requests
		s_next.pend = s_reg.pend & permit;
		if (pushed) s_next.pend[push_ch] = 1'b0;
		s_next.pend = s_next.pend | (chan_req & permit);
		// Read data stand one cycle only
		s_next.rdata = 16'h0000;
		if (REG_RD) begin
			unique case (REG_ADDR)
				`DMC_OFF_OPER: begin
					s_next.rdata[`DMC_BIT_GLOBAL_EN] = s_reg.global_transfer_enable;
					s_next.rdata[`DMC_BIT_NMI_FLAG] = s_reg.nmi_abort_flag;
					s_next.rdata[`DMC_BIT_ADDR_ERR_FLAG] = s_reg.addr_error_flag;
				end
				`DMC_OFF_SEL01:  s_next.rdata = s_reg.request_source_select_ch01;
				`DMC_OFF_SEL23:  s_next.rdata = s_reg.request_source_select_ch23;
				`DMC_OFF_STATUS: s_next.rdata = {7'h00, q_if.out_valid, s_reg.pend, s_reg.run};
				default:         s_next.rdata = 16'h0000;
			endcase
		end
		if (MANUAL_RST) begin
			s_next = RESET_STATE;
		end
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			s_reg <= RESET_STATE;
		end else if (CE) begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign REG_RDATA = s_reg.rdata;
	assign CH_RUN = s_reg.run;
	assign REQ_VALID = q_if.out_valid;
	assign REQ_CHANNEL = q_if.out_data;
endmodule : dmc_top

// >>> dv/dmc_top_sva.sv
// Port checker for the DMA control block
`include "dmc_defines.svh"
module dmc_top_sva (
	input wire logic        CORE_CLK,
	input wire logic        ARST_N,
	input wire logic        MANUAL_RST,
	input wire logic [7:0]  REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [15:0] REG_RDATA,
	input wire logic        NMI_EVENT,
	input wire logic        ADDR_ERROR_EVENT,
	input wire logic [3:0]  CHANNEL_ENABLE,
	input wire logic [3:0]  TRANSFER_END_FLAG,
	input wire logic [3:0]  UNIT_BUSY,
	input wire logic [3:0]  CH_RUN,
	input wire logic        REQ_VALID,
	input wire logic [1:0]  REQ_CHANNEL,
	input wire logic        REQ_READY
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!ARST_N);
	a_nmi_halts_run: assert property (NMI_EVENT |-> ##2 (CH_RUN & ~$past(CH_RUN & UNIT_BUSY)) == 4'h0)
		else $error("run kept after nmi");
	a_run_needs_chen: assert property ((CH_RUN & ~$past(CH_RUN) & ~$past(CHANNEL_ENABLE & ~TRANSFER_END_FLAG)) == 4'h0)
		else $error("run without enable");
	a_busy_keeps_run: assert property (!$past(MANUAL_RST) |-> ($past(CH_RUN & UNIT_BUSY) & ~CH_RUN) == 4'h0)
		else $error("busy unit cut");
	a_rdata_one_cycle: assert property (!$past(REG_RD) |-> REG_RDATA == 16'h0000)
		else $error("read data outside slot");
	a_nmi_flag_set: assert property (NMI_EVENT && !MANUAL_RST ##1 !REG_WR && !MANUAL_RST ##1
		(REG_RD && REG_ADDR == `DMC_OFF_OPER && !MANUAL_RST) |=> REG_RDATA[1]) else $error("nmi flag not set");
	a_aerr_halts_run: assert property (ADDR_ERROR_EVENT ##1 UNIT_BUSY == 4'h0 |=> CH_RUN == 4'h0)
		else $error("run kept after address error");
	a_off_halts_run: assert property (REG_WR && REG_ADDR == `DMC_OFF_OPER && !REG_WDATA[0]
		##1 UNIT_BUSY == 4'h0 |=> CH_RUN == 4'h0) else $error("run kept after disable");
	a_head_stands: assert property (REQ_VALID && !REQ_READY && !MANUAL_RST |=> REQ_VALID && $stable(REQ_CHANNEL))
		else $error("queue head moved");
	c_nmi: cover property (NMI_EVENT);
	c_pop: cover property (REQ_VALID && REQ_READY);
	c_aerr: cover property (ADDR_ERROR_EVENT);
endmodule : dmc_top_sva
bind dmc_top dmc_top_sva u_sva (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .MANUAL_RST(MANUAL_RST),
	.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.NMI_EVENT(NMI_EVENT), .ADDR_ERROR_EVENT(ADDR_ERROR_EVENT), .CHANNEL_ENABLE(CHANNEL_ENABLE),
	.TRANSFER_END_FLAG(TRANSFER_END_FLAG), .UNIT_BUSY(UNIT_BUSY), .CH_RUN(CH_RUN),
	.REQ_VALID(REQ_VALID), .REQ_CHANNEL(REQ_CHANNEL), .REQ_READY(REQ_READY));

// >>> dv/dmc_consumer.sv
// Request consumer model that pops the queue head, can stall
module dmc_consumer (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       stall,
	input  wire logic       valid,
	input  wire logic [1:0] chan,
	output logic            ready,
	output logic [1:0]      last,
	output logic [7:0]      taken
);
	timeunit 1ns;
	timeprecision 1ns;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ready <= 1'b0;
			last <= 2'h0;
			taken <= 8'h00;
		end else begin
			ready <= !stall;
			if (valid && ready) begin
				last <= chan;
				taken <= taken + 8'h01;
			end
		end
	end
endmodule : dmc_consumer

// >>> dv/dmc_top_bench.sv
// Self-checking bench for the DMA control block
`include "dmc_defines.svh"
module dmc_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [15:0] s01;
		logic [15:0] s23;
		logic [2:0]  b;
		logic [1:0]  ch;
	} dmc_row_type;
	localparam logic [7:0] OPER = `DMC_OFF_OPER;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        mrst = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        nmi = 1'b0;
	logic        aerr = 1'b0;
	logic [3:0]  chen = 4'hF;
	logic [3:0]  tend = 4'h0;
	logic [15:0] rs = 16'h8888;
	logic [3:0]  busy = 4'h0;
	logic [5:0]  preq = 6'h00;
	logic        stall = 1'b0;
	logic [15:0] rdata;
	logic [15:0] d;
	logic [3:0]  run;
	logic        rv;
	logic        rr;
	logic [1:0]  rch;
	logic [1:0]  last;
	logic [7:0]  taken;
	logic [7:0]  n;
	int          err_count = 0;
	int          total_checks = 0;
	dmc_row_type rows [6] = '{'{16'h0021, 16'h0000, 3'h0, 2'h0}, '{16'h0022, 16'h0000, 3'h1, 2'h0},
		'{16'h2900, 16'h0000, 3'h2, 2'h1}, '{16'h2A00, 16'h0000, 3'h3, 2'h1},
		'{16'h0000, 16'h0073, 3'h4, 2'h2}, '{16'h0000, 16'h7000, 3'h5, 2'h3}};
	always #25 clk = ~clk;
	dmc_top DUT (.CORE_CLK(clk), .ARST_N(arst_n), .CE(1'b1), .MANUAL_RST(mrst), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .NMI_EVENT(nmi),
		.ADDR_ERROR_EVENT(aerr), .CHANNEL_ENABLE(chen), .TRANSFER_END_FLAG(tend),
		.RESOURCE_SELECT_CODE(rs), .UNIT_BUSY(busy), .PERIPH_REQ(preq), .CH_RUN(run),
		.REQ_VALID(rv), .REQ_CHANNEL(rch), .REQ_READY(rr));
	dmc_consumer u_cons (.clk(clk), .arst_n(arst_n), .stall(stall), .valid(rv), .chan(rch),
		.ready(rr), .last(last), .taken(taken));
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : cyc
	task automatic wreg(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [7:0] a, output logic [15:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask : rreg
	task automatic ev(input logic [2:0] k);
		@(posedge clk);
		{mrst, aerr, nmi} <= k;
		@(posedge clk);
		{mrst, aerr, nmi} <= 3'h0;
	endtask : ev
	task automatic req(input logic [2:0] b);
		@(posedge clk);
		preq <= 6'h01 << b;
		@(posedge clk);
		preq <= 6'h00;
	endtask : req
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize
	initial begin
		repeat (3000) @(posedge clk);
		err_count++;
		summarize();
	end
	initial begin
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		rreg(OPER, d);
		chk("oper", 16'h0000, d);
		rreg(`DMC_OFF_SEL01, d);
		chk("sel01", 16'h0000, d);
		wreg(`DMC_OFF_SEL23, 16'hA5C3);
		rreg(`DMC_OFF_SEL23, d);
		chk("sel23", 16'hA5C3, d);
		wreg(8'h10, 16'hFFFF);
		rreg(8'h10, d);
		chk("unmapped", 16'h0000, d);
		wreg(OPER, 16'h0001);
		cyc(2);
		chk("run", 16'h000F, {12'h000, run});
		foreach (rows[i]) begin
			wreg(`DMC_OFF_SEL01, rows[i].s01);
			wreg(`DMC_OFF_SEL23, rows[i].s23);
			n = taken;
			req(rows[i].b);
			for (int j = 0; j < 20 && taken == n; j++) @(posedge clk);
			cyc(1);
			chk("taken", {8'h00, n + 8'h01}, {8'h00, taken});
			chk("chan", {14'h0000, rows[i].ch}, {14'h0000, last});
		end
		wreg(`DMC_OFF_SEL01, 16'h0021);
		rs <= 16'h8880;
		n = taken;
		req(3'h0);
		cyc(6);
		chk("taken", {8'h00, n}, {8'h00, taken});
		@(posedge clk);
		rs <= 16'h8888;
		stall <= 1'b1;
		cyc(2);
		repeat (10) req(3'h0);
		cyc(3);
		chk("valid", 16'h0001, {15'h0000, rv});
		chk("head", 16'h0000, {14'h0000, rch});
		rreg(`DMC_OFF_STATUS, d);
		chk("status", 16'h011F, d);
		@(posedge clk);
		stall <= 1'b0;
		cyc(30);
		chk("taken", {8'h00, n + 8'h09}, {8'h00, taken});
		wreg(OPER, 16'h0000);
		ev(3'h1);
		wreg(OPER, 16'h0001);
		cyc(2);
		chk("run", 16'h0000, {12'h000, run});
		rreg(OPER, d);
		chk("oper", 16'h0003, d);
		wreg(OPER, 16'h0001);
		cyc(2);
		chk("run", 16'h000F, {12'h000, run});
		@(posedge clk);
		busy <= 4'h1;
		ev(3'h1);
		rreg(OPER, d);
		chk("oper", 16'h0003, d);
		chk("run", 16'h0001, {12'h000, run});
		@(posedge clk);
		busy <= 4'h0;
		cyc(2);
		chk("run", 16'h0000, {12'h000, run});
		wreg(OPER, 16'h0001);
		ev(3'h2);
		cyc(2);
		chk("run", 16'h0000, {12'h000, run});
		rreg(OPER, d);
		chk("oper", 16'h0005, d);
		wreg(OPER, 16'h0001);
		tend <= 4'h2;
		chen <= 4'h7;
		cyc(2);
		chk("run", 16'h0005, {12'h000, run});
		wreg(OPER, 16'h0000);
		cyc(2);
		chk("run", 16'h0000, {12'h000, run});
		ev(3'h1);
		ev(3'h4);
		rreg(OPER, d);
		chk("oper", 16'h0000, d);
		summarize();
	end
endmodule : dmc_top_bench
